// file: design/uft_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the USB function control and trigger block.
package uft_pkg;

  // Register port widths.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;

  // Register indices on the byte-wide register port.
  localparam logic [1:0] CTRL_ADDR = 2'h0;
  localparam logic [1:0] DMA_ADDR = 2'h1;
  localparam logic [1:0] RESUME_ADDR = 2'h2;
  localparam logic [1:0] TRIG_ADDR = 2'h3;

  // Control register layout and reset value.
  localparam int unsigned CTRL_RESV_BIT = 7;
  localparam int unsigned CTRL_PIN_SEL_BIT = 6;
  localparam int unsigned CTRL_CLK_SEL_LSB = 2;
  localparam int unsigned CTRL_IFACE_RST_BIT = 1;
  localparam int unsigned CTRL_CORE_RST_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // Clock select codes; every other code is reserved.
  localparam logic [3:0] CLK_STOP = 4'h0;
  localparam logic [3:0] CLK_DOUBLE_24 = 4'h6;
  localparam logic [3:0] CLK_TRIPLE_16 = 4'h7;

  // DMA select layout and codes.
  localparam int unsigned DMA_EP2_LSB = 2;
  localparam int unsigned DMA_EP1_LSB = 0;
  localparam logic [7:0] DMA_MASK = 8'h0f;
  localparam logic [1:0] DMA_NONE = 2'h0;
  localparam logic [1:0] DMA_RESV = 2'h1;
  localparam logic [1:0] DMA_LINE0 = 2'h2;
  localparam logic [1:0] DMA_LINE1 = 2'h3;

  // Resume register layout.
  localparam int unsigned WAKE_STATUS_BIT = 1;
  localparam int unsigned RESUME_BIT = 0;
  localparam logic [7:0] RESUME_MASK = 8'h01;

  // Trigger register: six write-one bits in the low positions.
  localparam logic [7:0] TRIG_MASK = 8'h3f;

  // Clock stabilisation time and the clock rate that it is counted in.
  localparam int unsigned STAB_TIME_US = 2000;
  localparam int unsigned MCLK_KHZ = 40000;
  localparam int unsigned STAB_CYCLES = STAB_TIME_US * MCLK_KHZ / 1000;

  // Clock generator progress, Gray coded along the start-up path.
  typedef enum logic [1:0] {
    PLL_OFF = 2'b00,
    PLL_SETTLE = 2'b01,
    PLL_READY = 2'b11
  } uft_pll_type;

  // One request on the register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } uft_bus_type;

  // Trigger pulses, ordered as their bits in the trigger register.
  typedef struct packed {
    logic ep2_read_complete;
    logic ep1_packet_enable;
    logic ep3_packet_enable;
    logic control_out_read_complete;
    logic control_in_packet_enable;
    logic setup_read_complete;
  } uft_trig_type;

endpackage
`default_nettype wire

// file: design/uft_pulse_bits.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Write-one pulse bits: each masked bit written as 1 gives one pulse.
module uft_pulse_bits #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic hold, // Synchronous hold in reset.
  input wire logic fire, // Write strobe for this register.
  input wire logic [WIDTH-1:0] wdata, // Written data.
  input wire logic [WIDTH-1:0] mask, // Bits that exist.
  output logic [WIDTH-1:0] pulse // One-cycle pulses.
);

  // Each pulse lasts one cycle and nothing is remembered after it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulse <= '0;
    end else if (hold) begin
      pulse <= '0;
    end else if (fire) begin
      pulse <= wdata & mask;
    end else begin
      pulse <= '0;
    end
  end

endmodule
`default_nettype wire

// file: design/uft_top.sv
// Summary of operation
// - Control bit six routes suspend or timer out.
// - Clock select codes: stop, double, triple, reserved.
// - Clock ready after stabilisation once stop released.
// - Control register accessible even during module stop.
// - Interface reset holds all but control, ready, shared pin.
// - Core reset holds core, stops bus sync.
// - Endpoint two DMA select decodes request line.
// - Endpoint one DMA select decodes request line.
// - Reserved bits read zero, ignore writes, except control bit seven, which is stored and read back.
// - Wakeup status follows host feature requests.
// - Resume write ends suspend, reads zero.
// - Endpoint two read-complete hits active buffer.
// - Endpoint one packet-enable hits active buffer.
// - Endpoint three, control-in packet enable pulses.
// - Control-out read-complete frees next packet.
// - Data stage NAKs until setup read-complete.
// - Suspend pin high while function suspended, when control bit six is clear.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Control and trigger registers of a full-speed USB function.
module uft_top #(
  parameter int unsigned STAB_CYCLES = uft_pkg::STAB_CYCLES // Settle count.
) (
  input wire logic mclk, // System clock, 40 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire uft_pkg::uft_bus_type bus, // Register request.
  output logic [7:0] reg_rdata, // Read data, one cycle after read.
  input wire logic usb_module_stop_bit, // Module stop from system.
  input wire logic rtc_timer_output, // Timer output of the RTC.
  input wire logic usb_suspended, // Suspend state from the core.
  input wire logic host_wakeup_enable, // Host enabled remote wakeup.
  input wire logic host_wakeup_disable, // Host disabled remote wakeup.
  input wire logic ep1_dma_need, // Endpoint one wants DMA service.
  input wire logic ep2_dma_need, // Endpoint two wants DMA service.
  input wire logic ep1_active_buffer, // Active endpoint one buffer.
  input wire logic ep2_active_buffer, // Active endpoint two buffer.
  input wire logic setup_received, // A setup packet was stored.
  output logic suspend_indicator_out, // Shared suspend or timer pin.
  output logic pll_run, // Clock generator running.
  output logic pll_triple, // 1: triple 16 MHz, 0: double 24 MHz.
  output logic clock_ready_flag, // 48 MHz clock is stable.
  output logic protocol_clock_enable, // Clock gate to the core.
  output logic interface_reset_out, // Reset to interface modules.
  output logic protocol_core_reset, // Reset to the protocol core.
  output logic bus_sync_enable, // Core may track the USB bus.
  output logic first_dma_request_line, // First DMA request.
  output logic second_dma_request_line, // Second DMA request.
  output logic remote_wakeup_pulse, // Start remote wakeup signalling.
  output uft_pkg::uft_trig_type trig, // Trigger pulses.
  output logic [1:0] ep1_buffer_ready, // Per-buffer packet enable.
  output logic [1:0] ep2_buffer_release, // Per-buffer read complete.
  output logic data_stage_nak // Data stage is answered with NAK.
);
  import uft_pkg::*;

  localparam int unsigned CNT_W = $clog2(STAB_CYCLES + 1); // Counter width.

  logic [7:0] ctrl; // Control register.
  logic [3:0] dma_sel; // Both DMA select fields.
  logic wake_status; // Remote wakeup enabled by the host.
  logic data_stage_open; // Setup read complete was seen.
  uft_pll_type pll_state; // Clock generator progress.
  logic [CNT_W-1:0] settle_count; // Stabilisation counter.
  logic [5:0] trig_pulse; // Trigger pulses as a vector.
  logic [0:0] resume_pulse; // Device resume pulse.
  logic [3:0] clk_sel; // Clock select field.
  logic iface_rst; // Interface reset bit.
  logic code_valid; // Clock select names a usable source.
  logic wr_ctrl; // Control register write.
  logic wr_dma; // DMA select write.
  logic wr_resume; // Resume register write.
  logic wr_trig; // Trigger register write.

  //////////////////////////////////////////////////////////////////////////////
  // Address decode of the register port.

  // Writes are decoded with a plain if chain.
  always_comb begin
    wr_ctrl = 1'b0;
    wr_dma = 1'b0;
    wr_resume = 1'b0;
    wr_trig = 1'b0;
    if (bus.wr && bus.addr == CTRL_ADDR) begin
      wr_ctrl = 1'b1;
    end else if (bus.wr && bus.addr == DMA_ADDR) begin
      wr_dma = 1'b1;
    end else if (bus.wr && bus.addr == RESUME_ADDR) begin
      wr_resume = 1'b1;
    end else if (bus.wr && bus.addr == TRIG_ADDR) begin
      wr_trig = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register.

  // Never gated by module stop, and excluded from the interface reset.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= bus.wdata;
    end
  end

  assign clk_sel = ctrl[CTRL_CLK_SEL_LSB +: 4];
  assign iface_rst = ctrl[CTRL_IFACE_RST_BIT];

  // The interface reset holds all but this register, clock ready and the shared pin; the core also takes it.
  assign interface_reset_out = iface_rst;
  assign protocol_core_reset = ctrl[CTRL_CORE_RST_BIT] | iface_rst;

  // The core only follows the bus when out of reset and clocked.
  assign bus_sync_enable = !protocol_core_reset && clock_ready_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Clock generator control.

  // Only the two documented codes start the generator.
  assign code_valid = (clk_sel == CLK_DOUBLE_24) ||
                      (clk_sel == CLK_TRIPLE_16);

  // Start once module stop is released, then wait out stabilisation.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pll_state <= PLL_OFF;
      settle_count <= '0;
    end else if (usb_module_stop_bit || !code_valid) begin
      pll_state <= PLL_OFF;
      settle_count <= '0;
    end else begin
      case (pll_state)
        PLL_OFF: begin
          pll_state <= PLL_SETTLE;
          settle_count <= '0;
        end
        PLL_SETTLE: begin
          if (settle_count == CNT_W'(STAB_CYCLES - 1)) begin
            pll_state <= PLL_READY;
          end else begin
            settle_count <= settle_count + CNT_W'(1);
          end
        end
        PLL_READY: begin
          pll_state <= PLL_READY;
        end
        default: begin
          pll_state <= PLL_OFF;
        end
      endcase
    end
  end

  // The ready flag survives the interface reset by design.
  assign pll_run = (pll_state != PLL_OFF);
  assign pll_triple = (clk_sel == CLK_TRIPLE_16);
  assign clock_ready_flag = (pll_state == PLL_READY);
  assign protocol_clock_enable = clock_ready_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Shared output pin.

  // Registered so the pin never glitches while the select changes.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      suspend_indicator_out <= 1'b0;
    end else if (ctrl[CTRL_PIN_SEL_BIT]) begin
      suspend_indicator_out <= rtc_timer_output;
    end else begin
      suspend_indicator_out <= usb_suspended;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DMA request routing.

  // Reserved upper bits are simply not stored.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dma_sel <= '0;
    end else if (iface_rst) begin
      dma_sel <= '0;
    end else if (wr_dma) begin
      dma_sel <= bus.wdata[3:0];
    end
  end

  // Code 01 routes nowhere, like 00; a clash on one line is ORed.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      first_dma_request_line <= 1'b0;
      second_dma_request_line <= 1'b0;
    end else begin
      first_dma_request_line <=
        (ep2_dma_need && dma_sel[DMA_EP2_LSB +: 2] == DMA_LINE0) ||
        (ep1_dma_need && dma_sel[DMA_EP1_LSB +: 2] == DMA_LINE0);
      second_dma_request_line <=
        (ep2_dma_need && dma_sel[DMA_EP2_LSB +: 2] == DMA_LINE1) ||
        (ep1_dma_need && dma_sel[DMA_EP1_LSB +: 2] == DMA_LINE1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Remote wakeup.

  // The host enable wins over a disable arriving in the same cycle.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wake_status <= 1'b0;
    end else if (iface_rst) begin
      wake_status <= 1'b0;
    end else if (host_wakeup_enable) begin
      wake_status <= 1'b1;
    end else if (host_wakeup_disable) begin
      wake_status <= 1'b0;
    end
  end

  // The resume bit is a pulse only; it is never stored.
  uft_pulse_bits #(
    .WIDTH(1)
  ) resume_bits (
    .mclk(mclk),
    .reset_n(reset_n),
    .hold(iface_rst),
    .fire(wr_resume),
    .wdata(bus.wdata[RESUME_BIT]),
    .mask(RESUME_MASK[0:0]),
    .pulse(resume_pulse)
  );

  // Wakeup signalling only makes sense while suspended.
  assign remote_wakeup_pulse = resume_pulse[0] && usb_suspended;

  //////////////////////////////////////////////////////////////////////////////
  // FIFO triggers.

  // All six trigger bits share one write-one pulse generator.
  uft_pulse_bits #(
    .WIDTH(6)
  ) trig_bits (
    .mclk(mclk),
    .reset_n(reset_n),
    .hold(iface_rst),
    .fire(wr_trig),
    .wdata(bus.wdata[5:0]),
    .mask(TRIG_MASK[5:0]),
    .pulse(trig_pulse)
  );

  assign trig = trig_pulse;

  // Dual-buffer endpoints steer the pulse to the active buffer.
  assign ep1_buffer_ready = {trig.ep1_packet_enable && ep1_active_buffer,
                             trig.ep1_packet_enable &&
                             !ep1_active_buffer};
  assign ep2_buffer_release = {trig.ep2_read_complete && ep2_active_buffer,
                               trig.ep2_read_complete &&
                               !ep2_active_buffer};

  // A new setup packet closes the data stage and wins over a release.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_stage_open <= 1'b0;
    end else if (iface_rst || setup_received) begin
      data_stage_open <= 1'b0;
    end else if (trig.setup_read_complete) begin
      data_stage_open <= 1'b1;
    end
  end

  assign data_stage_nak = !data_stage_open;

  //////////////////////////////////////////////////////////////////////////////
  // Register read-back.

  // Read data is registered; unmapped bits and write-only bits read zero.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (bus.rd && bus.addr == CTRL_ADDR) begin
      reg_rdata <= ctrl;
    end else if (bus.rd && bus.addr == DMA_ADDR) begin
      reg_rdata <= {4'h0, dma_sel};
    end else if (bus.rd && bus.addr == RESUME_ADDR) begin
      reg_rdata <= {6'h00, wake_status, 1'b0};
    end else if (bus.rd) begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // With bit six set, the pin follows the timer output one cycle later.
  pin_route_a: assert property (ctrl[CTRL_PIN_SEL_BIT] |=>
    suspend_indicator_out == $past(rtc_timer_output))
    else $error("shared pin not routed to timer output");

  // The generator never runs on a stop or reserved code.
  clk_code_a: assert property (pll_run |-> $past(code_valid))
    else $error("clock generator running on bad code");

  // Ready appears only after the full settle count.
  clk_ready_a: assert property ($rose(clock_ready_flag) |->
    $past(settle_count) == CNT_W'(STAB_CYCLES - 1) &&
    !$past(usb_module_stop_bit))
    else $error("clock ready before stabilisation");

  // Control writes land even under module stop.
  ctrl_write_a: assert property (wr_ctrl && usb_module_stop_bit |=>
    ctrl == $past(bus.wdata))
    else $error("control write lost under module stop");

  // Interface reset clears held state and triggers next cycle.
  iface_hold_a: assert property (iface_rst |=>
    dma_sel == 4'h0 && !wake_status && trig_pulse == 6'h00 &&
    !resume_pulse[0] && !data_stage_open)
    else $error("interface reset does not hold state");

  // Core reset keeps the core off the bus.
  core_hold_a: assert property (ctrl[CTRL_CORE_RST_BIT] |->
    protocol_core_reset && !bus_sync_enable)
    else $error("core follows bus while in reset");

  // A selected first line carries the endpoint two need.
  dma_route_a: assert property (ep2_dma_need &&
    dma_sel[DMA_EP2_LSB +: 2] == DMA_LINE0 |=> first_dma_request_line)
    else $error("endpoint two request lost");

  // Reserved DMA bits read as zero.
  dma_resv_a: assert property (bus.rd && bus.addr == DMA_ADDR |=>
    reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  // Host enable sets the wakeup status.
  wake_stat_a: assert property (host_wakeup_enable && !iface_rst |=>
    wake_status)
    else $error("wakeup status not set");

  // Resume gives exactly one pulse while suspended.
  resume_a: assert property (wr_resume && bus.wdata[RESUME_BIT] &&
    !iface_rst ##1 usb_suspended |-> remote_wakeup_pulse ##1
    !resume_pulse[0])
    else $error("resume pulse missing or stretched");

  // Read complete goes to the active buffer only.
  ep2_buf_a: assert property (trig.ep2_read_complete |->
    ep2_buffer_release[ep2_active_buffer] &&
    !ep2_buffer_release[!ep2_active_buffer])
    else $error("read complete on wrong buffer");

  // A setup packet forces NAK in the data stage.
  setup_nak_a: assert property (setup_received |=> data_stage_nak)
    else $error("data stage open after setup");

  start_cov_c: cover property ($rose(clock_ready_flag));
  trig_cov_c: cover property (wr_trig ##1 trig.control_in_packet_enable);
  open_cov_c: cover property ($fell(data_stage_nak));
  wake_cov_c: cover property (remote_wakeup_pulse);

endmodule
`default_nettype wire

// file: tb/uft_host_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Behavioural USB host and core side as seen by the control block.
module uft_host_model (
  input wire logic mclk, // System clock.
  input wire logic remote_wakeup_pulse, // Wakeup request from the block.
  output logic usb_suspended, // Bus suspend state.
  output logic host_wakeup_enable, // Feature set pulse.
  output logic host_wakeup_disable, // Feature clear pulse.
  output logic setup_received // Setup packet stored.
);
  timeunit 1ns;
  timeprecision 100ps;
  // All lines start idle.
  initial begin
    {usb_suspended, host_wakeup_enable} = 2'h0;
    {host_wakeup_disable, setup_received} = 2'h0;
  end
  // Sends one event: 0 enable, 1 disable, 2 setup, else suspend.
  task automatic send(input int k);
    @(posedge mclk) #2;
    case (k)
      0: host_wakeup_enable = 1'b1;
      1: host_wakeup_disable = 1'b1;
      2: setup_received = 1'b1;
      default: usb_suspended = 1'b1;
    endcase
    @(posedge mclk) #2;
    {host_wakeup_enable, host_wakeup_disable, setup_received} = 3'h0;
  endtask
  // The bus leaves suspend once the block signals remote wakeup.
  always @(posedge mclk) begin
    if (remote_wakeup_pulse === 1'b1) begin
      #2 usb_suspended = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the control and trigger registers.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import uft_pkg::*;
  localparam int unsigned STAB = 20; // Short settle count.
  logic mclk, reset_n, usb_module_stop_bit, rtc_timer_output;
  logic usb_suspended, host_wakeup_enable, host_wakeup_disable;
  logic ep1_dma_need, ep2_dma_need, ep1_active_buffer, ep2_active_buffer;
  logic setup_received, suspend_indicator_out, pll_run, pll_triple;
  logic clock_ready_flag, protocol_clock_enable, interface_reset_out;
  logic protocol_core_reset, bus_sync_enable, first_dma_request_line;
  logic second_dma_request_line, remote_wakeup_pulse, data_stage_nak;
  logic [7:0] reg_rdata;
  logic [1:0] ep1_buffer_ready, ep2_buffer_release;
  uft_bus_type bus;
  uft_trig_type trig;
  int n_fail = 0;
  int num_checks = 0;
  // The block with a short clock settle count.
  uft_top #(.STAB_CYCLES(STAB)) u_uft_top (
    .mclk, .reset_n, .bus, .reg_rdata, .usb_module_stop_bit,
    .rtc_timer_output, .usb_suspended, .host_wakeup_enable,
    .host_wakeup_disable, .ep1_dma_need, .ep2_dma_need,
    .ep1_active_buffer, .ep2_active_buffer, .setup_received,
    .suspend_indicator_out, .pll_run, .pll_triple, .clock_ready_flag,
    .protocol_clock_enable, .interface_reset_out, .protocol_core_reset,
    .bus_sync_enable, .first_dma_request_line, .second_dma_request_line,
    .remote_wakeup_pulse, .trig, .ep1_buffer_ready, .ep2_buffer_release,
    .data_stage_nak
  );
  // The host and bus side.
  uft_host_model u_uft_host_model (
    .mclk, .remote_wakeup_pulse, .usb_suspended, .host_wakeup_enable,
    .host_wakeup_disable, .setup_received
  );
  // A 40 MHz clock.
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits n edges and steps just past the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // One register write, taken at the next edge.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    cyc(1);
    bus = '{1'b1, 1'b0, a, d};
    cyc(1);
    bus.wr = 1'b0;
  endtask
  // One register read, compared the cycle after it is taken.
  task automatic rd_chk(input string nm, input logic [1:0] a,
                        input logic [7:0] e);
    cyc(1);
    bus = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    bus.rd = 1'b0;
    chk(nm, e, reg_rdata);
  endtask
  // Waits for the clock ready flag under a bound.
  task automatic wait_ready();
    int i;
    for (i = 0; i < 200 && clock_ready_flag !== 1'b1; i++) cyc(1);
    if (i == 200) begin
      n_fail++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    bus = '0;
    usb_module_stop_bit = 1'b0;
    {rtc_timer_output, ep1_dma_need, ep2_dma_need} = 3'h0;
    {ep1_active_buffer, ep2_active_buffer} = 2'h0;
    repeat (12) @(posedge mclk);
    #2 reset_n = 1'b1;
    // Reset state, with the clock stopped by code zero.
    rd_chk("control", CTRL_ADDR, CTRL_RESET);
    chk("core_reset", 8'h01, {7'h0, protocol_core_reset});
    chk("bus_sync", 8'h00, {7'h0, bus_sync_enable});
    chk("nak", 8'h01, {7'h0, data_stage_nak});
    chk("iface_rst", 8'h01, {7'h0, interface_reset_out});
    cyc(4);
    chk("pll_off", 8'h00, {7'h0, pll_run});
    wr(DMA_ADDR, 8'h0b);
    rd_chk("dma_held", DMA_ADDR, 8'h00);
    // A reserved code must not start the generator.
    usb_module_stop_bit = 1'b1;
    wr(CTRL_ADDR, 8'h17);
    rd_chk("control_stopped", CTRL_ADDR, 8'h17);
    usb_module_stop_bit = 1'b0;
    cyc(4);
    chk("pll_resv", 8'h00, {7'h0, pll_run});
    // Tripling code; ready only after the settle count.
    usb_module_stop_bit = 1'b1;
    wr(CTRL_ADDR, 8'h1f);
    usb_module_stop_bit = 1'b0;
    cyc(2);
    chk("pll_run", 8'h03, {6'h0, pll_run, pll_triple});
    cyc(10);
    chk("early_ready", 8'h00, {7'h0, clock_ready_flag});
    wait_ready();
    chk("clk_en", 8'h01, {7'h0, protocol_clock_enable});
    // Doubling code after a fresh stop.
    usb_module_stop_bit = 1'b1;
    cyc(2);
    chk("ready_drop", 8'h00, {7'h0, clock_ready_flag});
    wr(CTRL_ADDR, 8'h1b);
    usb_module_stop_bit = 1'b0;
    wait_ready();
    chk("double", 8'h00, {7'h0, pll_triple});
    // Start-up order: interface first, then the core.
    wr(CTRL_ADDR, 8'h19);
    chk("sync_held", 8'h00, {7'h0, bus_sync_enable});
    chk("iface_off", 8'h00, {7'h0, interface_reset_out});
    wr(CTRL_ADDR, 8'h18);
    chk("sync_on", 8'h01, {7'h0, bus_sync_enable});
    wr(DMA_ADDR, 8'hfb);
    rd_chk("dma_resv", DMA_ADDR, 8'h0b);
    // Every select code on each endpoint.
    for (int k = 0; k < 8; k++) begin
      {ep2_dma_need, ep1_dma_need} = k[2] ? 2'b10 : 2'b01;
      wr(DMA_ADDR,
         k[2] ? {4'h0, k[1:0], 2'h0} : {6'h0, k[1:0]});
      cyc(2);
      chk("dma_lines", {6'h0, k[1:0] == 2'h2, k[1:0] == 2'h3},
          {6'h0, first_dma_request_line,
           second_dma_request_line});
    end
    {ep2_dma_need, ep1_dma_need} = 2'b00;
    // Shared pin: timer source, then suspend source.
    wr(CTRL_ADDR, 8'h58);
    rtc_timer_output = 1'b1;
    cyc(2);
    chk("pin_timer", 8'h01, {7'h0, suspend_indicator_out});
    wr(CTRL_ADDR, 8'h18);
    u_uft_host_model.send(3);
    cyc(2);
    chk("pin_susp", 8'h01, {7'h0, suspend_indicator_out});
    // Wakeup status and resume.
    u_uft_host_model.send(0);
    rd_chk("wake_on", RESUME_ADDR, 8'h02);
    wr(RESUME_ADDR, 8'hff);
    chk("wake_pulse", 8'h01, {7'h0, remote_wakeup_pulse});
    rd_chk("resume_rd", RESUME_ADDR, 8'h02);
    cyc(3);
    chk("pin_awake", 8'h00, {7'h0, suspend_indicator_out});
    wr(RESUME_ADDR, 8'h01);
    chk("wake_idle", 8'h00, {7'h0, remote_wakeup_pulse});
    u_uft_host_model.send(1);
    rd_chk("wake_off", RESUME_ADDR, 8'h00);
    // Each trigger pulses once; buffer pulses follow the active buffer.
    u_uft_host_model.send(2);
    chk("nak_setup", 8'h01, {7'h0, data_stage_nak});
    {ep2_active_buffer, ep1_active_buffer} = 2'b01;
    for (int i = 0; i < 6; i++) begin
      wr(TRIG_ADDR, 8'hc0 | (8'h01 << i));
      chk("trig", 8'h01 << i, {2'h0, trig});
      chk("ep1_rdy", {6'h0, i == 4, 1'b0}, {6'h0, ep1_buffer_ready});
      chk("ep2_rel", {7'h0, i == 5}, {6'h0, ep2_buffer_release});
      cyc(1);
      chk("trig_gone", 8'h00, {2'h0, trig});
    end
    rd_chk("trig_reg", TRIG_ADDR, 8'h00);
    chk("nak_open", 8'h00, {7'h0, data_stage_nak});
    u_uft_host_model.send(2);
    chk("nak_again", 8'h01, {7'h0, data_stage_nak});
    // Interface reset again, together with core reset.
    wr(CTRL_ADDR, 8'h1b);
    rd_chk("dma_reset", DMA_ADDR, 8'h00);
    chk("ready_kept", 8'h01, {7'h0, clock_ready_flag});
    chk("core_held", 8'h01, {7'h0, protocol_core_reset});
    chk("iface_again", 8'h01, {7'h0, interface_reset_out});
    give_verdict();
  end
endmodule
`default_nettype wire
